//--- src/pfc_consts.svh
/*
 * Constants for the parallel flash host controller: command addresses,
 * command data codes and pin cycle timing.
 * Assumes a 250 MHz controller clock.
 */
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

// =====================================================================
// Command addresses (bits 14..0 compared by the device)
`define PFC_ADDR_UNLOCK1   15'h5555
`define PFC_ADDR_UNLOCK2   15'h2AAA
`define PFC_ADDR_ID_MAKER  15'h0000
`define PFC_ADDR_ID_PART   15'h0001

// =====================================================================
// Command data codes
`define PFC_DATA_UNLOCK1   8'hAA
`define PFC_DATA_UNLOCK2   8'h55
`define PFC_DATA_PROGRAM   8'hA0
`define PFC_DATA_ERASE     8'h80
`define PFC_DATA_SECTOR    8'h30
`define PFC_DATA_CHIP      8'h10
`define PFC_DATA_ID_ENTRY  8'h90
`define PFC_DATA_ID_EXIT   8'hF0

// =====================================================================
// Sector select field starts at address line 12
`define PFC_SECTOR_LSB     12

// =====================================================================
// Pin timing: clock period and phase lengths in ns
`define PFC_CLK_PERIOD_NS  4
`define PFC_SETUP_NS       20
`define PFC_STROBE_NS      40
`define PFC_HOLD_NS        20
`define PFC_SETUP_CYC  ((`PFC_SETUP_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_STROBE_CYC ((`PFC_STROBE_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_HOLD_CYC   ((`PFC_HOLD_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)

`endif

//--- src/pfc_pkg.sv
/*
 * Types for the parallel flash host controller.
 * Assumes nothing beyond the constants header.
 */
package pfc_pkg;

    // Host commands
    typedef enum logic [2:0] {
        PFC_CMD_READ    = 3'h0,
        PFC_CMD_PROGRAM = 3'h1,
        PFC_CMD_SECTOR  = 3'h2,
        PFC_CMD_CHIP    = 3'h3,
        PFC_CMD_ID_IN   = 3'h4,
        PFC_CMD_ID_OUT  = 3'h5,
        PFC_CMD_ID_OUT3 = 3'h6
    } pfc_cmd_e;

    // Controller states, Gray coded along setup-strobe-hold
    typedef enum logic [2:0] {
        PFC_IDLE   = 3'b000,
        PFC_SETUP  = 3'b001,
        PFC_STROBE = 3'b011,
        PFC_HOLD   = 3'b010,
        PFC_NEXT   = 3'b110
    } pfc_state_e;

endpackage : pfc_pkg

//--- src/pfc_host.sv
/*
 * Host-side controller for a byte-wide parallel flash. Turns one user
 * command into the pin write sequence the flash expects, or one read.
 * Assumes the flash pins are wired straight to the ports below and that
 * data pin input is synchronous to ref_clk.
 */
`include "pfc_consts.svh"

module pfc_host #(
    parameter int ADDR_W = 19
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // User command port
    input  wire logic              cmd_valid,
    input  wire pfc_pkg::pfc_cmd_e cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [7:0]        cmd_data,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output logic [7:0]             rsp_data,
    // Flash pins
    output logic [ADDR_W-1:0]      flash_addr,
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    input  wire logic [7:0]        data_pins_in,
    output logic [7:0]             data_pins_out,
    output logic                   data_pins_oe
);

    localparam int SETUP_CYC  = `PFC_SETUP_CYC;
    localparam int STROBE_CYC = `PFC_STROBE_CYC;
    localparam int HOLD_CYC   = `PFC_HOLD_CYC;

    // =================================================================
    // Elaboration checks
    if (ADDR_W < 16 || ADDR_W > 24) begin : g_bad_addr_w
        $error("ADDR_W must lie between 16 and 24");
    end
    if (SETUP_CYC < 1 || SETUP_CYC > 255) begin : g_bad_setup
        $error("Setup phase must last 1 to 255 cycles");
    end
    if (STROBE_CYC < 2 || STROBE_CYC > 255) begin : g_bad_strobe
        $error("Strobe phase must last 2 to 255 cycles");
    end
    if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_bad_hold
        $error("Hold phase must last 1 to 255 cycles");
    end

    // =================================================================
    // Internal state
    pfc_pkg::pfc_state_e state;
    pfc_pkg::pfc_cmd_e   op;
    logic [ADDR_W-1:0]   user_addr;
    logic [7:0]          user_data;
    logic [2:0]          step;
    logic [2:0]          last_step;
    logic [7:0]          timer;
    logic                is_read;
    logic                accept;
    logic [14:0]         seq_addr;
    logic [7:0]          seq_data;
    logic                seq_user;
    logic [ADDR_W-1:0]   pin_addr;
    logic [2:0]          next_last_step;

    assign accept  = cmd_valid && cmd_ready;
    assign is_read = (op == pfc_pkg::PFC_CMD_READ);

    // =================================================================
    // Number of bus cycles in each command, less one
    always_comb begin
        next_last_step = 3'h0;
        case (cmd_op)
            pfc_pkg::PFC_CMD_PROGRAM: begin
                next_last_step = 3'h3;
            end
            pfc_pkg::PFC_CMD_SECTOR,
            pfc_pkg::PFC_CMD_CHIP: begin
                next_last_step = 3'h5;
            end
            pfc_pkg::PFC_CMD_ID_IN,
            pfc_pkg::PFC_CMD_ID_OUT3: begin
                next_last_step = 3'h2;
            end
            default: begin
                next_last_step = 3'h0;
            end
        endcase
    end

    // =================================================================
    // Sequence table: address and data of each bus cycle
    always_comb begin
        seq_addr = `PFC_ADDR_UNLOCK1;
        seq_data = `PFC_DATA_UNLOCK1;
        seq_user = 1'b0;
        case (step)
            3'h0: begin
                if (op == pfc_pkg::PFC_CMD_ID_OUT) begin
                    seq_user = 1'b1;
                    seq_data = `PFC_DATA_ID_EXIT;
                end else if (op == pfc_pkg::PFC_CMD_READ) begin
                    seq_user = 1'b1;
                end
            end
            3'h1, 3'h4: begin
                seq_addr = `PFC_ADDR_UNLOCK2;
                seq_data = `PFC_DATA_UNLOCK2;
            end
            3'h2: begin
                case (op)
                    pfc_pkg::PFC_CMD_PROGRAM: begin
                        seq_data = `PFC_DATA_PROGRAM;
                    end
                    pfc_pkg::PFC_CMD_ID_IN: begin
                        seq_data = `PFC_DATA_ID_ENTRY;
                    end
                    pfc_pkg::PFC_CMD_ID_OUT3: begin
                        seq_data = `PFC_DATA_ID_EXIT;
                    end
                    default: begin
                        seq_data = `PFC_DATA_ERASE;
                    end
                endcase
            end
            3'h3: begin
                if (op == pfc_pkg::PFC_CMD_PROGRAM) begin
                    seq_user = 1'b1;
                    seq_data = user_data;
                end
            end
            3'h5: begin
                if (op == pfc_pkg::PFC_CMD_SECTOR) begin
                    seq_user = 1'b1;
                    seq_data = `PFC_DATA_SECTOR;
                end else begin
                    seq_data = `PFC_DATA_CHIP;
                end
            end
            default: begin
                seq_addr = `PFC_ADDR_UNLOCK1;
            end
        endcase
    end

    // Cycles at the fixed unlock addresses hold the lines above bit 14 at a defined zero
    assign pin_addr = seq_user ? user_addr : {{(ADDR_W-15){1'b0}}, seq_addr};

    // =================================================================
    // Command capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op        <= pfc_pkg::PFC_CMD_READ;
            user_addr <= '0;
            user_data <= 8'h00;
            last_step <= 3'h0;
        end else if (accept) begin
            op        <= cmd_op;
            user_addr <= cmd_addr;
            user_data <= cmd_data;
            last_step <= next_last_step;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_ready <= 1'b0;
        end else if (accept) begin
            cmd_ready <= 1'b0;
        end else if (state == pfc_pkg::PFC_IDLE) begin
            cmd_ready <= 1'b1;
        end
    end

    // =================================================================
    // Bus cycle sequencer: setup, strobe, hold, gap
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= pfc_pkg::PFC_IDLE;
            step  <= 3'h0;
            timer <= 8'h00;
        end else begin
            case (state)
                pfc_pkg::PFC_IDLE: begin
                    if (accept) begin
                        state <= pfc_pkg::PFC_SETUP;
                        step  <= 3'h0;
                        timer <= 8'(SETUP_CYC - 1);
                    end
                end
                pfc_pkg::PFC_SETUP: begin
                    if (timer == 8'h00) begin
                        state <= pfc_pkg::PFC_STROBE;
                        timer <= 8'(STROBE_CYC - 1);
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                pfc_pkg::PFC_STROBE: begin
                    if (timer == 8'h00) begin
                        state <= pfc_pkg::PFC_HOLD;
                        timer <= 8'(HOLD_CYC - 1);
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                pfc_pkg::PFC_HOLD: begin
                    if (timer == 8'h00) begin
                        state <= pfc_pkg::PFC_NEXT;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                pfc_pkg::PFC_NEXT: begin
                    if (step == last_step) begin
                        state <= pfc_pkg::PFC_IDLE;
                    end else begin
                        state <= pfc_pkg::PFC_SETUP;
                        step  <= step + 3'h1;
                        timer <= 8'(SETUP_CYC - 1);
                    end
                end
                default: begin
                    state <= pfc_pkg::PFC_IDLE;
                end
            endcase
        end
    end

    // =================================================================
    // Flash pins, one cycle behind the sequencer state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flash_ce_n    <= 1'b1;
            flash_oe_n    <= 1'b1;
            flash_we_n    <= 1'b1;
            flash_addr    <= '0;
            data_pins_out <= 8'h00;
            data_pins_oe  <= 1'b0;
        end else begin
            flash_addr    <= pin_addr;
            data_pins_out <= seq_data;
            case (state)
                pfc_pkg::PFC_SETUP,
                pfc_pkg::PFC_HOLD: begin
                    // Address settles before the strobe, data holds after it
                    flash_ce_n   <= 1'b0;
                    flash_oe_n   <= 1'b1;
                    flash_we_n   <= 1'b1;
                    data_pins_oe <= !is_read;
                end
                pfc_pkg::PFC_STROBE: begin
                    flash_ce_n   <= 1'b0;
                    flash_oe_n   <= !is_read;
                    flash_we_n   <= is_read;
                    data_pins_oe <= !is_read;
                end
                default: begin
                    flash_ce_n   <= 1'b1;
                    flash_oe_n   <= 1'b1;
                    flash_we_n   <= 1'b1;
                    data_pins_oe <= 1'b0;
                end
            endcase
        end
    end

    // =================================================================
    // Read data, taken one cycle before the output gate pulse ends
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            if (state == pfc_pkg::PFC_STROBE && timer == 8'h00 && is_read) begin
                rsp_valid <= 1'b1;
                rsp_data  <= data_pins_in;
            end
        end
    end

endmodule : pfc_host

//--- bench/pfc_chk.sv
/* Pin checker bound to pfc_host. Assumes one clock and a synchronous reset. */
module pfc_chk #(parameter int ADDR_W = 19) (input wire logic ref_clk, rst, flash_ce_n,
    flash_oe_n, flash_we_n, data_pins_oe, input wire logic [ADDR_W-1:0] flash_addr);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_WR: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n) else $error("bad write");
    AST_RD: assert property (!flash_oe_n |-> flash_we_n && !data_pins_oe) else $error("clash");
    AST_DV: assert property (!flash_we_n |-> data_pins_oe) else $error("no write data");
    AST_PW: assert property ($fell(flash_we_n) |-> !flash_we_n [*8]) else $error("short we");
    AST_SU: assert property ($fell(flash_we_n) |-> $stable(flash_addr)) else $error("setup");
    AST_AH: assert property (!flash_we_n ##1 !flash_we_n |-> $stable(flash_addr)) else $error("a");
    AST_DH: assert property ($rose(flash_we_n) |-> $past(data_pins_oe)) else $error("hold");
    AST_CE: assert property ($fell(flash_oe_n) |-> !flash_ce_n) else $error("read unselected");
endmodule : pfc_chk
bind pfc_host pfc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- bench/pfc_flash.sv
/* Flash model: decoder, ID mode, 256-byte array. Assumes host pins wired direct. */
module pfc_flash #(parameter logic [7:0] MK = 8'h3C, PT = 8'hA6) ( // Codes arbitrary
    input wire logic ce_n, oe_n, we_n, input wire logic [18:0] a,
    input wire logic [7:0] di, output logic [7:0] dq, output logic qe);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] m [256], v;
    int s = 0;
    logic id = 0, busy = 0;
    wire u1 = a[14:0] == 15'h5555, u2 = a[14:0] == 15'h2AAA;
    assign v = id ? (a[0] ? PT : MK) : m[a[7:0]];
    assign qe = !ce_n && !oe_n && we_n;
    assign dq = qe ? v : ~v;
    always @(posedge (ce_n | we_n)) if (oe_n && !busy) begin
        if (s == 3 || s == 6 && (di == 8'h30 || u1 && di == 8'h10)) begin
            busy = 1'b1;
            busy <= #40 1'b0;
        end
        if (s == 3) m[a[7:0]] = di;
        if (s == 6 && (di == 8'h30 || u1 && di == 8'h10)) m = '{default: 8'hFF};
        if (s == 2 && u1 && di == 8'h90) id = 1;
        if (di == 8'hF0 && (s == 0 || s == 2 && u1)) id = 0;
        case (s)
            0, 4: s = u1 && di == 8'hAA ? s + 1 : 0;
            1, 5: s = u2 && di == 8'h55 ? s + 1 : 0;
            2: s = u1 && di == 8'hA0 ? 3 : u1 && di == 8'h80 ? 4 : 0;
            default: s = 0;
        endcase
    end
endmodule : pfc_flash

//--- bench/parallel_flash_command_decoder_bench.sv
/* Bench: pfc_host driving a flash model. Assumes a 4 ns clock. */
module parallel_flash_command_decoder_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] MK = 8'h3C, PT = 8'hA6; // Arbitrary codes
    logic ref_clk = 0, rst = 1, cmd_valid = 0, cmd_ready, rsp_valid, oe, ce_n, oe_n, we_n, qe;
    pfc_pkg::pfc_cmd_e cmd_op = pfc_pkg::PFC_CMD_READ, ops [7];
    logic [18:0] cmd_addr = 0, fa, ad, ra [7];
    logic [7:0] cmd_data = 0, rsp_data, po, dq, bus, d, e, ex [7], q [$];
    int err_count = 0, checks_done = 0, cyc = 0;
    assign bus = oe ? po : dq;
    pfc_host u_dut (.ref_clk, .rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready,
        .rsp_valid, .rsp_data, .flash_addr(fa), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .data_pins_in(bus), .data_pins_out(po), .data_pins_oe(oe));
    pfc_flash #(.MK(MK), .PT(PT)) u_mem (.a(fa), .ce_n, .oe_n, .we_n, .di(bus), .dq, .qe);
    task automatic close_out;
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic go(pfc_pkg::pfc_cmd_e op, logic [18:0] a);
        @(posedge ref_clk);
        #1 cmd_op = op;
        {cmd_addr, cmd_data, cmd_valid} = {a, d, 1'b1};
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        #1 cmd_valid = 0;
    endtask : go
    initial forever #2 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        cyc++;
        if (rsp_valid === 1'b1) begin
            e = q.pop_front();
            checks_done++;
            if (rsp_data !== e) begin
                err_count++;
                $display("BAD %0t %h %h", $time, rsp_data, e);
            end
        end
        if (cyc > 40000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        void'($urandom(37));
        repeat (20) @(posedge ref_clk);
        #1 rst = 0;
        ad = 19'($urandom);
        d = 8'($urandom);
        ops = '{pfc_pkg::PFC_CMD_CHIP, pfc_pkg::PFC_CMD_PROGRAM, pfc_pkg::PFC_CMD_ID_IN,
            pfc_pkg::PFC_CMD_ID_OUT, pfc_pkg::PFC_CMD_ID_IN, pfc_pkg::PFC_CMD_ID_OUT3,
            pfc_pkg::PFC_CMD_SECTOR};
        ra = '{ad, ad, 19'h0, ad, 19'h1, ad, ad};
        ex = '{8'hFF, d, MK, d, PT, d, 8'hFF};
        foreach (ra[i]) begin
            go(ops[i], ad);
            q.push_back(ex[i]);
            go(pfc_pkg::PFC_CMD_READ, ra[i]);
        end
        repeat (50) @(posedge ref_clk);
        close_out();
    end
endmodule : parallel_flash_command_decoder_bench
